// *** rtl/rbac_defines.svh ***
`ifndef RBAC_DEFINES_SVH
`define RBAC_DEFINES_SVH

`define RBAC_NUM_REGIONS   4
`define RBAC_BOOT_ADDR_0   8'h54
`define RBAC_BOOT_STEP     8'h04
`define RBAC_BIT_IO        0
`define RBAC_LOC_HI        2
`define RBAC_LOC_LO        1
`define RBAC_BIT_PREF      3
`define RBAC_ATTR_HI       3
`define RBAC_WID_HI        31
`define RBAC_WID_LO        30
`define RBAC_BIT_MIRROR    29
`define RBAC_ADDR_LO       4
`define RBAC_ZERO_WORD     32'h0000_0000
`define RBAC_ATTR_KEEP     32'hc000_000f
`define RBAC_IO_MAX_BYTES  32'h0000_0100
`define RBAC_WID_OFF       2'h0
`define RBAC_WID_8         2'h1
`define RBAC_WID_16        2'h2
`define RBAC_WID_32        2'h3
`define RBAC_LOC_ANY32     2'h0
`define RBAC_LOC_LOW1M     2'h1
`define RBAC_LOC_ANY64     2'h2

`endif

// *** rtl/rbac_pkg.sv ***
package rbac_pkg;

	typedef struct packed {
		logic        io_space;
		logic [1:0]  location;
		logic        prefetch;
		logic [1:0]  width;
		logic        enabled;
		logic        loc_bad;
		logic        io_oversize;
	} rbac_region_info_t;

	typedef struct packed {
		logic        valid;
		logic [1:0]  index;
		logic        write;
		logic [31:0] wdata;
	} rbac_cfg_req_t;

	typedef struct packed {
		logic        req;
		logic [7:0]  addr;
	} rbac_boot_req_t;

	typedef enum logic [1:0] {
		RBAC_ST_IDLE = 2'b00,
		RBAC_ST_REQ  = 2'b01,
		RBAC_ST_WAIT = 2'b10,
		RBAC_ST_DONE = 2'b11
	} rbac_load_state_t;

endpackage

// *** rtl/rbac_region_base.sv ***
`timescale 1ns/1ps
`include "rbac_defines.svh"

module rbac_region_base #(
	parameter int NUM_REGIONS = `RBAC_NUM_REGIONS
) (
	input  wire logic                    mclk_in,
	input  wire logic                    rst_n_in,
	// boot device word port
	input  wire logic                    boot_present_in,
	output logic                         boot_req_out,
	output logic [7:0]                   boot_addr_out,
	input  wire logic                    boot_ack_in,
	input  wire logic [31:0]             boot_data_in,
	// host configuration access
	input  wire logic                    cfg_valid_in,
	input  wire logic [1:0]              cfg_index_in,
	input  wire logic                    cfg_write_in,
	input  wire logic [31:0]             cfg_wdata_in,
	output logic                         cfg_rvalid_out,
	output logic [31:0]                  cfg_rdata_out,
	// region view toward the pass-through logic
	output logic                         init_done_out,
	output logic [NUM_REGIONS-1:0]       region_enable_out,
	output logic [NUM_REGIONS-1:0]       region_io_out,
	output logic [NUM_REGIONS-1:0]       region_prefetch_out,
	output logic [2*NUM_REGIONS-1:0]     region_location_out,
	output logic [2*NUM_REGIONS-1:0]     region_width_out,
	output logic [32*NUM_REGIONS-1:0]    region_base_out,
	output logic [NUM_REGIONS-1:0]       region_io_oversize_out
);

	initial begin
		if (NUM_REGIONS != `RBAC_NUM_REGIONS) begin
			$error("NUM_REGIONS must equal the documented region count");
		end
	end

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [31:0]                  mask [NUM_REGIONS];
	logic [31:0]                  base [NUM_REGIONS];
	logic [31:0]                  next_mask [NUM_REGIONS];
	logic [31:0]                  next_base [NUM_REGIONS];
	rbac_pkg::rbac_load_state_t   state;
	rbac_pkg::rbac_load_state_t   next_state;
	logic [1:0]                   load_idx;
	logic [1:0]                   next_load_idx;
	rbac_pkg::rbac_boot_req_t     boot_q;
	rbac_pkg::rbac_boot_req_t     next_boot_q;
	rbac_pkg::rbac_cfg_req_t      req;
	logic                         next_rvalid;
	logic [31:0]                  next_rdata;
	logic [31:0]                  rd_word;
	rbac_pkg::rbac_region_info_t  info [NUM_REGIONS];
	logic                         present_s1;
	logic                         present_s2;
	logic                         present_s3;
	logic                         present_q;
	logic                         next_present_q;

	always_comb begin
		req.valid = cfg_valid_in;
		req.index = cfg_index_in;
		req.write = cfg_write_in;
		req.wdata = cfg_wdata_in;
	end

	// ----------------------------------------------------------------
	// boot strap pin synchroniser
	// ----------------------------------------------------------------
	// level taken once the last two stages agree
	always_comb begin
		next_present_q = present_q;
		if (present_s2 == present_s3) begin
			next_present_q = present_s3;
		end
	end

	// no reset: the chain settles while reset is held
	always_ff @(posedge mclk_in) begin
		present_s1 <= boot_present_in;
		present_s2 <= present_s1;
		present_s3 <= present_s2;
		present_q  <= next_present_q;
	end

	// ----------------------------------------------------------------
	// boot download sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state    = state;
		next_load_idx = load_idx;
		next_boot_q   = boot_q;
		case (state)
			rbac_pkg::RBAC_ST_IDLE: begin
				if (present_q) begin
					next_state = rbac_pkg::RBAC_ST_REQ;
				end else begin
					next_state = rbac_pkg::RBAC_ST_DONE;
				end
			end
			rbac_pkg::RBAC_ST_REQ: begin
				next_boot_q.req  = 1'b1;
				next_boot_q.addr = `RBAC_BOOT_ADDR_0
				                   + {4'h0, load_idx, 2'h0};
				next_state       = rbac_pkg::RBAC_ST_WAIT;
			end
			rbac_pkg::RBAC_ST_WAIT: begin
				if (boot_ack_in) begin
					next_boot_q.req = 1'b0;
					if (load_idx == 2'(NUM_REGIONS - 1)) begin
						next_state = rbac_pkg::RBAC_ST_DONE;
					end else begin
						next_load_idx = load_idx + 2'h1;
						next_state    = rbac_pkg::RBAC_ST_REQ;
					end
				end
			end
			rbac_pkg::RBAC_ST_DONE: begin
				next_boot_q.req = 1'b0;
			end
			default: begin
				next_state = rbac_pkg::RBAC_ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// per-region mask, base and decode
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_REGIONS; g++) begin : gen_region
			rbac_region_decode u_decode (
				.mask_in  (mask[g]),
				.info_out (info[g])
			);

			always_comb begin
				next_mask[g] = mask[g];
				next_base[g] = base[g];
				if (state == rbac_pkg::RBAC_ST_WAIT && boot_ack_in
				    && load_idx == 2'(g)) begin
					next_mask[g] = boot_data_in;
					// attributes and width follow the mask from load onward
					next_base[g] = boot_data_in & `RBAC_ATTR_KEEP;
				end else if (state == rbac_pkg::RBAC_ST_DONE && req.valid
				             && req.write && req.index == 2'(g)) begin
					// only address bits the mask leaves set take host data
					next_base[g][31:`RBAC_ADDR_LO] =
						(req.wdata[31:`RBAC_ADDR_LO] & mask[g][31:`RBAC_ADDR_LO])
						| (base[g][31:`RBAC_ADDR_LO] & ~mask[g][31:`RBAC_ADDR_LO]);
					next_base[g][`RBAC_WID_HI:`RBAC_WID_LO] =
						mask[g][`RBAC_WID_HI:`RBAC_WID_LO];
				end
			end

			always_ff @(posedge mclk_in) begin
				if (!rst_n_in) begin
					mask[g] <= `RBAC_ZERO_WORD;
					base[g] <= `RBAC_ZERO_WORD;
				end else begin
					mask[g] <= next_mask[g];
					base[g] <= next_base[g];
				end
			end

			always_ff @(posedge mclk_in) begin
				if (!rst_n_in) begin
					region_enable_out[g]          <= 1'b0;
					region_io_out[g]              <= 1'b0;
					region_prefetch_out[g]        <= 1'b0;
					region_location_out[2*g +: 2] <= 2'h0;
					region_width_out[2*g +: 2]    <= `RBAC_WID_OFF;
					region_base_out[32*g +: 32]   <= `RBAC_ZERO_WORD;
					region_io_oversize_out[g]     <= 1'b0;
				end else begin
					region_enable_out[g]          <= info[g].enabled;
					region_io_out[g]              <= info[g].io_space;
					region_prefetch_out[g]        <= info[g].prefetch;
					region_location_out[2*g +: 2] <= info[g].location;
					region_width_out[2*g +: 2]    <= info[g].width;
					region_base_out[32*g +: 32]   <= {2'h0, base[g][`RBAC_BIT_MIRROR:0]};
					region_io_oversize_out[g]     <= info[g].io_oversize;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// configuration read path
	// ----------------------------------------------------------------
	always_comb begin
		rd_word     = base[req.index];
		// width bits are hidden; both mirror bit 29
		rd_word[`RBAC_WID_HI:`RBAC_WID_LO] = {2{rd_word[`RBAC_BIT_MIRROR]}};
		next_rvalid = req.valid && !req.write;
		next_rdata  = next_rvalid ? rd_word : `RBAC_ZERO_WORD;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			state          <= rbac_pkg::RBAC_ST_IDLE;
			load_idx       <= 2'h0;
			boot_q         <= '0;
			cfg_rvalid_out <= 1'b0;
			cfg_rdata_out  <= `RBAC_ZERO_WORD;
			init_done_out  <= 1'b0;
		end else begin
			state          <= next_state;
			load_idx       <= next_load_idx;
			boot_q         <= next_boot_q;
			cfg_rvalid_out <= next_rvalid;
			cfg_rdata_out  <= next_rdata;
			init_done_out  <= next_state == rbac_pkg::RBAC_ST_DONE;
		end
	end

	always_comb begin
		boot_req_out  = boot_q.req;
		boot_addr_out = boot_q.addr;
	end

endmodule

// *** rtl/rbac_region_decode.sv ***
`timescale 1ns/1ps
`include "rbac_defines.svh"

module rbac_region_decode (
	input  wire logic [31:0]               mask_in,
	output rbac_pkg::rbac_region_info_t    info_out
);
	logic [31:0] size_bytes;

	always_comb begin
		// lowest address bit left writable by the mask gives the size
		// width bits carry no size, so count them as set
		size_bytes = ~{2'h3, mask_in[`RBAC_BIT_MIRROR:`RBAC_ADDR_LO], {`RBAC_ADDR_LO{1'b0}}}
		             + 32'h0000_0001;
		info_out.io_space    = mask_in[`RBAC_BIT_IO];
		info_out.location    = mask_in[`RBAC_BIT_IO] ? `RBAC_LOC_ANY32
		                       : mask_in[`RBAC_LOC_HI:`RBAC_LOC_LO];
		info_out.prefetch    = ~mask_in[`RBAC_BIT_IO] & mask_in[`RBAC_BIT_PREF];
		info_out.width       = mask_in[`RBAC_WID_HI:`RBAC_WID_LO];
		info_out.enabled     = mask_in[`RBAC_WID_HI:`RBAC_WID_LO] != `RBAC_WID_OFF;
		info_out.loc_bad     = ~mask_in[`RBAC_BIT_IO]
		                       & mask_in[`RBAC_LOC_HI];
		info_out.io_oversize = mask_in[`RBAC_BIT_IO]
		                       & (size_bytes > `RBAC_IO_MAX_BYTES);
	end

endmodule

// *** verification/rbac_boot_model.sv ***
`timescale 1ns/1ps
module rbac_boot_model #(
	parameter logic [127:0] MASKS = '0
) (
	input  wire logic        mclk_in,
	input  wire logic        boot_req_in,
	input  wire logic [7:0]  boot_addr_in,
	output logic             boot_ack_out = 1'b0,
	output logic [31:0]      boot_data_out = 32'h0
);
	// ----
	// boot word store, odd words answer late
	// ----
	logic [7:0] off;
	logic [2:0] cnt = 3'h0;
	assign off = boot_addr_in - 8'h54;
	always @(posedge mclk_in) begin
		boot_ack_out <= 1'b0;
		boot_data_out <= ~boot_data_out;
		if (!boot_req_in || boot_ack_out) cnt <= 3'h0;
		else if (cnt < {1'b0, off[2], off[2]}) cnt <= cnt + 3'h1;
		else begin
			boot_ack_out <= 1'b1;
			boot_data_out <= MASKS[32*off[3:2] +: 32];
		end
	end
endmodule

// *** verification/rbac_region_base_asserts.sv ***
`timescale 1ns/1ps
module rbac_region_base_asserts #(
	parameter int NUM_REGIONS = 4
) (
	input  wire logic                     mclk_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     boot_present_in,
	input  wire logic                     boot_req_out,
	input  wire logic [7:0]               boot_addr_out,
	input  wire logic                     boot_ack_in,
	input  wire logic                     cfg_valid_in,
	input  wire logic                     cfg_write_in,
	input  wire logic                     cfg_rvalid_out,
	input  wire logic [31:0]              cfg_rdata_out,
	input  wire logic                     init_done_out,
	input  wire logic [NUM_REGIONS-1:0]   region_enable_out,
	input  wire logic [NUM_REGIONS-1:0]   region_io_out,
	input  wire logic [2*NUM_REGIONS-1:0] region_width_out
);
	// ----
	// checks
	// ----
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	logic [NUM_REGIONS-1:0] wid_nz;
	always_comb for (int i = 0; i < NUM_REGIONS; i++) wid_nz[i] = |region_width_out[2*i +: 2];
	sequence mid_ack_s;
		boot_req_out && boot_ack_in && boot_addr_out != 8'h60;
	endsequence
	sequence last_ack_s;
		boot_req_out && boot_ack_in && boot_addr_out == 8'h60;
	endsequence
	sequence next_req_s;
		!boot_req_out ##1 boot_req_out && boot_addr_out == $past(boot_addr_out, 2) + 8'h04;
	endsequence
	boot_step_a: assert property (mid_ack_s |=> next_req_s)
		else $error("boot address did not advance");
	boot_done_a: assert property (last_ack_s |=> init_done_out && !boot_req_out)
		else $error("download did not finish");
	read_answer_a: assert property (cfg_valid_in && !cfg_write_in |=> cfg_rvalid_out)
		else $error("read not answered");
	read_cause_a: assert property (cfg_rvalid_out |-> $past(cfg_valid_in && !cfg_write_in))
		else $error("read data without read");
	width_mirror_a: assert property (cfg_rvalid_out |->
		cfg_rdata_out[31:30] == {2{cfg_rdata_out[29]}})
		else $error("width bits not mirrored");
	region_off_a: assert property (region_enable_out == wid_nz)
		else $error("enable does not follow width");
	no_boot_a: assert property (!boot_present_in && init_done_out |-> region_enable_out == '0)
		else $error("region enabled without boot device");
	attr_hold_a: assert property (init_done_out && $past(init_done_out, 2)
		|-> $stable(region_io_out) && $stable(region_width_out))
		else $error("attributes changed after download");
endmodule
bind rbac_region_base rbac_region_base_asserts #(.NUM_REGIONS(NUM_REGIONS)) u_chk (.mclk_in,
	.rst_n_in, .boot_present_in, .boot_req_out, .boot_addr_out, .boot_ack_in, .cfg_valid_in,
	.cfg_write_in, .cfg_rvalid_out, .cfg_rdata_out, .init_done_out, .region_enable_out,
	.region_io_out, .region_width_out);

// *** verification/tb_region_base_address_config.sv ***
`timescale 1ns/1ps
module tb_region_base_address_config;
	localparam logic [127:0] MASKS = {32'h7ffff001, 32'hffffff81, 32'h3ffffff8, 32'hbffff002};
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic boot_present_in = 1'b0;
	logic cfg_valid_in = 1'b0;
	logic [1:0] cfg_index_in = 2'h0;
	logic cfg_write_in = 1'b0;
	logic [31:0] cfg_wdata_in = 32'h0;
	logic boot_req, boot_ack, rvalid, done;
	logic [7:0] boot_addr, loc, wid;
	logic [31:0] boot_data, rdata, lfsr = 32'hde67588e;
	logic [3:0] en, io, pf, ovs;
	logic [127:0] base;
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int checks = 0;
	initial forever #12.5 mclk_in = ~mclk_in;
	rbac_region_base u_dut (.mclk_in, .rst_n_in, .boot_present_in, .boot_req_out(boot_req),
		.boot_addr_out(boot_addr), .boot_ack_in(boot_ack), .boot_data_in(boot_data),
		.cfg_valid_in, .cfg_index_in, .cfg_write_in, .cfg_wdata_in, .cfg_rvalid_out(rvalid),
		.cfg_rdata_out(rdata), .init_done_out(done), .region_enable_out(en),
		.region_io_out(io), .region_prefetch_out(pf), .region_location_out(loc),
		.region_width_out(wid), .region_base_out(base), .region_io_oversize_out(ovs));
	rbac_boot_model #(.MASKS(MASKS)) u_boot (.mclk_in, .boot_req_in(boot_req),
		.boot_addr_in(boot_addr), .boot_ack_out(boot_ack), .boot_data_out(boot_data));
	// ----
	// helpers
	// ----
	function automatic logic [31:0] nxt(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] exp_rd(logic [31:0] m, logic [31:0] w);
		logic [29:0] v;
		v = {w[29:4] & m[29:4], m[3:0]};
		return {v[29], v[29], v};
	endfunction
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic op(logic [1:0] i, logic w, logic [31:0] d, logic [31:0] e);
		cfg_valid_in = 1'b1;
		cfg_index_in = i;
		cfg_write_in = w;
		cfg_wdata_in = d;
		if (!w) exp_q.push_back(e);
		@(posedge mclk_in);
		#2;
	endtask
	task automatic rst_run(logic p);
		rst_n_in = 1'b0;
		boot_present_in = p;
		repeat (10) @(posedge mclk_in);
		#2;
		rst_n_in = 1'b1;
	endtask
	task automatic wait_done();
		for (int k = 0; k < 200 && done !== 1'b1; k++) @(posedge mclk_in);
		#2;
		if (done !== 1'b1) begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	// read results against the oldest note
	always @(negedge mclk_in) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, rdata, 32'h0);
			end else begin
				chk(rdata, exp_q.pop_front());
			end
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		rst_run(1'b0);
		wait_done();
		for (int i = 0; i < 4; i++) op(i[1:0], 1'b0, 32'h0, 32'h0);
		cfg_valid_in = 1'b0;
		chk({28'h0, en}, 32'h0);
		repeat (2) @(posedge mclk_in);
		#2;
		rst_run(1'b1);
		op(2'h0, 1'b1, 32'hffffffff, 32'h0);
		cfg_valid_in = 1'b0;
		wait_done();
		op(2'h0, 1'b0, 32'h0, exp_rd(MASKS[31:0], 32'h0));
		chk({8'h0, en, io, pf[1:0], ovs[3:2], loc[3:0], wid}, 32'h00dca172);
		chk({24'h0, pf[3:2], ovs[1:0], loc[7:4]}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			op(i[1:0], 1'b1, 32'hffffffff, 32'h0);
			op(i[1:0], 1'b0, 32'h0, exp_rd(MASKS[32*i +: 32], 32'hffffffff));
		end
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			op(i[1:0], 1'b1, lfsr & (MASKS[32*i +: 32] | 32'hc000000f), 32'h0);
			op(i[1:0], 1'b0, 32'h0, exp_rd(MASKS[32*i +: 32], lfsr));
			chk(base[32*i +: 32], exp_rd(MASKS[32*i +: 32], lfsr) & 32'h3fffffff);
		end
		cfg_valid_in = 1'b0;
		repeat (3) @(posedge mclk_in);
		if (exp_q.size() != 0) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
		end
		report_and_stop();
	end
endmodule
